//--- hw/bec_pkg.sv
package bec_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    // Printed offsets are not multiples of four, so they are indices.
    localparam logic [15:0] BEC_IDX_BOOST_CTRL = 16'h4064;
    localparam logic [15:0] BEC_IDX_BOOST_SLEEP = 16'h4065;
    localparam logic [15:0] BEC_IDX_EXT_CTRL = 16'h4066;
    localparam logic [15:0] BEC_IDX_SEQ_CTRL = 16'h4070;
    localparam logic [15:0] BEC_IDX_IRQ_STATUS = 16'h4071;
    localparam logic [15:0] BEC_IDX_IRQ_MASK = 16'h4072;
    localparam logic [15:0] BEC_IDX_KEY = 16'h4073;
    localparam logic [15:0] BEC_IDX_STATE = 16'h4074;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int BEC_ERR_ACT_LSB = 14;
    localparam int BEC_HWC_SRC_LSB = 11;
    localparam int BEC_HWC_MODE_BIT = 8;
    localparam int BEC_RANGE_LSB = 2;
    localparam int BEC_FBSRC_BIT = 0;
    localparam int BEC_SW_EN_BIT = 1;
    localparam int BEC_SLPENA_BIT = 8;
    localparam int BEC_ON_SLOT_LSB = 13;
    localparam int BEC_SLP_SLOT_LSB = 5;
    localparam int BEC_EXT_HWCENA_BIT = 8;
    localparam int BEC_EXT_SW_EN_BIT = 0;
    localparam logic [15:0] BEC_BOOST_CTRL_RST = 16'h0104;
    localparam logic [15:0] BEC_BOOST_CTRL_MASK = 16'hd90f;
    localparam logic [15:0] BEC_BOOST_SLEEP_MASK = 16'h0100;
    localparam logic [15:0] BEC_EXT_CTRL_MASK = 16'hf9e1;
    localparam logic [15:0] BEC_KEY_VALUE = 16'h9716;

    localparam logic [1:0] BEC_ACT_IGNORE = 2'h0;
    localparam logic [1:0] BEC_ACT_SHUTDOWN = 2'h1;
    localparam logic [1:0] BEC_ACT_RESET = 2'h2;
    localparam logic [2:0] BEC_SLOT_HWE1 = 3'h6;
    localparam logic [2:0] BEC_SLOT_HWE2 = 3'h7;
    localparam logic [2:0] BEC_LAST_SLOT = 3'h5;
    localparam logic [2:0] BEC_FIRST_SLOT = 3'h1;

    // Interrupt status bits.
    localparam int BEC_IRQ_UV = 0;
    localparam int BEC_IRQ_UP_DONE = 1;
    localparam int BEC_IRQ_SLP_DONE = 2;
    localparam int BEC_IRQ_W = 3;

    typedef enum logic [2:0] {
        BEC_ST_IDLE = 3'b001,
        BEC_ST_UP = 3'b010,
        BEC_ST_DOWN = 3'b100
    } bec_seq_e;

endpackage

//--- hw/bec_ctrl.sv
// Contract
// - Undervoltage action field: 00 ignore, 01 converter off, 10 system reset, 11 reserved.
// - Every undervoltage event raises an interrupt, whatever the action field says.
// - Boost hardware source: none, input 1, input 2, or either input.
// - Mode bit 1 disables boost while source asserted; 0 means software enable only.
// - Two-bit range field selects output range, default 01.
// - Range field changes only while the security key permits protected writes.
// - Feedback bit picks current sink one (0) or two (1), default 0.
// - In sleep the boost is off unless sleep-enable is 1, then follows software enable.
// - Power-on slot: 000 never, 001-101 slots 1-5, 110/111 hardware enable 1/2.
// - External enable hardware source: none, input 1, input 2, or either input.
// - Hardware enable bit 0 ignores inputs; 1 lets asserted input force output low.
// - Sleep slot 001-101 deasserts in slots 5 down to 1; others leave output.
//
// Added by the designer: the APB slave port.
module bec_ctrl
    import bec_pkg::*;
#(
    parameter int SLOT_CYCLES = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hw_control_in1,
    input wire logic hw_control_in2,
    input wire logic hw_enable1,
    input wire logic hw_enable2,
    input wire logic boost_undervoltage,
    input wire logic power_up_req,
    input wire logic sleep_req,
    output logic boost_enable,
    output logic [1:0] boost_voltage_range,
    output logic boost_feedback_select,
    output logic system_reset_req,
    output logic external_enable_output_one,
    output logic [2:0] timeslot,
    output logic sleep_state,
    output logic irq
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] boost_ctrl;
        logic [15:0] boost_sleep;
        logic [15:0] ext_ctrl;
        logic [BEC_IRQ_W-1:0] irq_status;
        logic [BEC_IRQ_W-1:0] irq_mask;
        logic key_open;
        logic uv_shut;
        bec_seq_e seq;
        logic [2:0] slot;
        logic [7:0] slot_cnt;
        logic ext_seq_on;
        logic asleep;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic boost_en;
        logic ext_en;
        logic sys_reset;
        logic irq;
    } bec_state_s;

    bec_state_s q_r;
    bec_state_s q_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic hw_src_active(input logic [1:0] src, input logic h1,
                                           input logic h2);
        case (src)
            2'h1: hw_src_active = h1;
            2'h2: hw_src_active = h2;
            2'h3: hw_src_active = h1 | h2;
            default: hw_src_active = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] st, input logic [15:0] msk);
        logic [15:0] v;
        v = old;
        if (st[0])
        begin
            v[7:0] = wd[7:0];
        end
        if (st[1])
        begin
            v[15:8] = wd[15:8];
        end
        merge16 = v & msk;
    endfunction

    logic [15:0] idx;
    logic setup;
    logic access;
    logic hw_boost;
    logic hw_ext;
    logic [2:0] on_slot;
    logic [2:0] slp_slot;
    logic [BEC_IRQ_W-1:0] irq_set;
    logic [15:0] rd;
    logic hit;

    always_comb
    begin
        q_nxt = q_r;
        idx = paddr[17:2];
        setup = psel & ~penable;
        access = psel & penable & q_r.pready;
        irq_set = '0;
        rd = 16'h0000;
        hit = 1'b1;
        on_slot = q_r.ext_ctrl[BEC_ON_SLOT_LSB +: 3];
        slp_slot = q_r.ext_ctrl[BEC_SLP_SLOT_LSB +: 3];

        // ------------------------------------------------------------
        // APB slave: answer is registered, no wait state.
        // ------------------------------------------------------------
        // Writes land at the edge that samples pready high, never at setup.
        q_nxt.pready = setup;
        case (idx)
            BEC_IDX_BOOST_CTRL: rd = q_r.boost_ctrl;
            BEC_IDX_BOOST_SLEEP: rd = q_r.boost_sleep;
            BEC_IDX_EXT_CTRL: rd = q_r.ext_ctrl;
            BEC_IDX_SEQ_CTRL: rd = 16'h0000;
            BEC_IDX_IRQ_STATUS: rd = {13'h0000, q_r.irq_status};
            BEC_IDX_IRQ_MASK: rd = {13'h0000, q_r.irq_mask};
            BEC_IDX_KEY: rd = {15'h0000, q_r.key_open};
            BEC_IDX_STATE: rd = {8'h00, q_r.slot, q_r.seq, q_r.uv_shut, q_r.asleep};
            default: hit = 1'b0;
        endcase
        q_nxt.prdata = setup ? {16'h0000, rd} : 32'h0000_0000;
        q_nxt.pslverr = setup & ~hit;

        if (access & pwrite & hit)
        begin
            case (idx)
                BEC_IDX_BOOST_CTRL:
                begin
                    q_nxt.boost_ctrl = merge16(q_r.boost_ctrl, pwdata, pstrb,
                                               BEC_BOOST_CTRL_MASK);
                    // A locked key keeps the range field as it was.
                    if (!q_r.key_open)
                    begin
                        q_nxt.boost_ctrl[BEC_RANGE_LSB +: 2] =
                            q_r.boost_ctrl[BEC_RANGE_LSB +: 2];
                    end
                end
                BEC_IDX_BOOST_SLEEP:
                    q_nxt.boost_sleep = merge16(q_r.boost_sleep, pwdata, pstrb,
                                                BEC_BOOST_SLEEP_MASK);
                BEC_IDX_EXT_CTRL:
                    q_nxt.ext_ctrl = merge16(q_r.ext_ctrl, pwdata, pstrb, BEC_EXT_CTRL_MASK);
                BEC_IDX_IRQ_MASK: q_nxt.irq_mask = pwdata[BEC_IRQ_W-1:0];
                BEC_IDX_KEY: q_nxt.key_open = (pwdata[15:0] == BEC_KEY_VALUE);
                BEC_IDX_SEQ_CTRL:
                    if (pwdata[0])
                    begin
                        q_nxt.uv_shut = 1'b0;
                    end
                default: q_nxt.irq_mask = q_r.irq_mask;
            endcase
        end

        // ------------------------------------------------------------
        // Undervoltage handling.
        // ------------------------------------------------------------
        q_nxt.sys_reset = 1'b0;
        if (boost_undervoltage)
        begin
            irq_set[BEC_IRQ_UV] = 1'b1;
            case (q_r.boost_ctrl[BEC_ERR_ACT_LSB +: 2])
                BEC_ACT_SHUTDOWN: q_nxt.uv_shut = 1'b1;
                BEC_ACT_RESET: q_nxt.sys_reset = 1'b1;
                default: q_nxt.uv_shut = q_nxt.uv_shut;
            endcase
        end

        // ------------------------------------------------------------
        // Timeslot sequencer.
        // ------------------------------------------------------------
        q_nxt.slot_cnt = q_r.slot_cnt + 8'h01;
        case (q_r.seq)
            BEC_ST_IDLE:
            begin
                q_nxt.slot_cnt = 8'h00;
                if (power_up_req & q_r.asleep)
                begin
                    q_nxt.seq = BEC_ST_UP;
                    q_nxt.slot = BEC_FIRST_SLOT;
                    q_nxt.asleep = 1'b0;
                end
                else if (sleep_req & ~q_r.asleep)
                begin
                    q_nxt.seq = BEC_ST_DOWN;
                    q_nxt.slot = BEC_LAST_SLOT;
                    q_nxt.asleep = 1'b1;
                end
            end
            BEC_ST_UP, BEC_ST_DOWN:
            begin
                if (q_r.slot_cnt == 8'(SLOT_CYCLES - 1))
                begin
                    q_nxt.slot_cnt = 8'h00;
                    if (q_r.seq == BEC_ST_UP)
                    begin
                        if (on_slot == q_r.slot)
                        begin
                            q_nxt.ext_seq_on = 1'b1;
                        end
                        q_nxt.slot = q_r.slot + 3'h1;
                        if (q_r.slot == BEC_LAST_SLOT)
                        begin
                            q_nxt.seq = BEC_ST_IDLE;
                            q_nxt.slot = 3'h0;
                            irq_set[BEC_IRQ_UP_DONE] = 1'b1;
                        end
                    end
                    else
                    begin
                        // Code 001 lands in slot 5, code 101 in slot 1.
                        if ((slp_slot >= BEC_FIRST_SLOT) && (slp_slot <= BEC_LAST_SLOT) &&
                            (3'(3'h6 - slp_slot) == q_r.slot))
                        begin
                            q_nxt.ext_seq_on = 1'b0;
                        end
                        q_nxt.slot = q_r.slot - 3'h1;
                        if (q_r.slot == BEC_FIRST_SLOT)
                        begin
                            q_nxt.seq = BEC_ST_IDLE;
                            q_nxt.slot = 3'h0;
                            irq_set[BEC_IRQ_SLP_DONE] = 1'b1;
                        end
                    end
                end
            end
            default:
            begin
                q_nxt.seq = BEC_ST_IDLE;
                q_nxt.slot = 3'h0;
            end
        endcase

        // ------------------------------------------------------------
        // Output enables.
        // ------------------------------------------------------------
        hw_boost = hw_src_active(q_r.boost_ctrl[BEC_HWC_SRC_LSB +: 2],
                                 hw_control_in1, hw_control_in2);
        hw_ext = hw_src_active(q_r.ext_ctrl[BEC_HWC_SRC_LSB +: 2],
                               hw_control_in1, hw_control_in2);

        q_nxt.boost_en = q_r.boost_ctrl[BEC_SW_EN_BIT] & ~q_r.uv_shut &
                         ~(q_r.boost_ctrl[BEC_HWC_MODE_BIT] & hw_boost) &
                         (~q_r.asleep | q_r.boost_sleep[BEC_SLPENA_BIT]);

        case (on_slot)
            BEC_SLOT_HWE1: q_nxt.ext_en = hw_enable1;
            BEC_SLOT_HWE2: q_nxt.ext_en = hw_enable2;
            3'h0: q_nxt.ext_en = q_r.ext_ctrl[BEC_EXT_SW_EN_BIT] & ~q_r.asleep;
            default: q_nxt.ext_en = q_r.ext_seq_on & q_r.ext_ctrl[BEC_EXT_SW_EN_BIT];
        endcase
        if (q_r.ext_ctrl[BEC_EXT_HWCENA_BIT] & hw_ext)
        begin
            q_nxt.ext_en = 1'b0;
        end

        // ------------------------------------------------------------
        // Interrupts: set wins over a write-one clear.
        // ------------------------------------------------------------
        if (access & pwrite & (idx == BEC_IDX_IRQ_STATUS))
        begin
            q_nxt.irq_status = q_r.irq_status & ~pwdata[BEC_IRQ_W-1:0];
        end
        q_nxt.irq_status = q_nxt.irq_status | irq_set;
        q_nxt.irq = |(q_nxt.irq_status & q_r.irq_mask);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q_r <= '{boost_ctrl: BEC_BOOST_CTRL_RST, seq: BEC_ST_IDLE, asleep: 1'b1,
                     default: '0};
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    // Fields drive the analogue side straight from their flops.
    assign boost_voltage_range = q_r.boost_ctrl[BEC_RANGE_LSB +: 2];
    assign boost_feedback_select = q_r.boost_ctrl[BEC_FBSRC_BIT];
    assign boost_enable = q_r.boost_en;
    assign external_enable_output_one = q_r.ext_en;
    assign system_reset_req = q_r.sys_reset;
    assign timeslot = q_r.slot;
    assign sleep_state = q_r.asleep;
    assign irq = q_r.irq;
    assign prdata = q_r.prdata;
    assign pready = q_r.pready;
    assign pslverr = q_r.pslverr;

endmodule

//--- bench/bec_ctrl_asserts.sv
module bec_ctrl_asserts
    import bec_pkg::*;
#(
    parameter int SLOT_CYCLES = 4
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic boost_undervoltage,
    input wire logic system_reset_req,
    input wire logic [2:0] timeslot,
    input wire logic sleep_state
);
    // ------------------------------------------------------------
    // Slot length counter
    // ------------------------------------------------------------
    // Counting in helper logic keeps the check valid for any slot length.
    logic [2:0] last_ts_r;
    int run_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_ts_r <= 3'h0;
            run_r <= 0;
        end
        else
        begin
            last_ts_r <= timeslot;
            run_r <= (timeslot != last_ts_r) ? 1 : run_r + 1;
        end
    end

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence slot_leave_s;
        last_ts_r != 3'h0 && timeslot != last_ts_r;
    endsequence

    apb_ready_a: assert property (apb_setup_s |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    uv_reset_a: assert property (system_reset_req |-> $past(boost_undervoltage))
        else $error("reset request without undervoltage");
    slot_step_a: assert property (slot_leave_s and timeslot != 3'h0 |->
        timeslot == last_ts_r + 3'h1 || timeslot == last_ts_r - 3'h1)
        else $error("timeslot skipped");
    slot_start_a: assert property (timeslot == 3'h1 && last_ts_r == 3'h0 |-> !sleep_state)
        else $error("power-up slot while asleep");
    slot_hold_a: assert property (slot_leave_s |-> run_r == SLOT_CYCLES)
        else $error("timeslot length wrong");
    slot_range_a: assert property (timeslot <= BEC_LAST_SLOT)
        else $error("timeslot out of range");
endmodule

bind bec_ctrl bec_ctrl_asserts #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (.pclk, .presetn, .psel,
    .penable, .prdata, .pready, .pslverr, .boost_undervoltage, .system_reset_req, .timeslot,
    .sleep_state);

//--- bench/tb_boost_and_enable_output_ctrl.sv
module tb_boost_and_enable_output_ctrl
    import bec_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_req = 0;
    logic hw_control_in1 = 0, hw_control_in2 = 0, hw_enable1 = 0, hw_enable2 = 0;
    logic boost_undervoltage = 0, power_up_req = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
    logic pready, pslverr, boost_enable, boost_feedback_select, system_reset_req, er, rs;
    logic external_enable_output_one, sleep_state, irq;
    logic [1:0] boost_voltage_range;
    logic [2:0] timeslot;
    int num_errors = 0, checks_done = 0, cycles = 0;

    bec_ctrl #(.SLOT_CYCLES(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .hw_control_in1, .hw_control_in2,
        .hw_enable1, .hw_enable2, .boost_undervoltage, .power_up_req, .sleep_req,
        .boost_enable, .boost_voltage_range, .boost_feedback_select, .system_reset_req,
        .external_enable_output_one, .timeslot, .sleep_state, .irq);

    always #20 pclk = ~pclk;

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    // The master never assumes the answer time: only the bench timeout ends the wait.
    task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {14'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wt(input logic [2:0] s);
        int n;
        n = 0;
        do @(negedge pclk); while (timeslot !== s && ++n < 200);
        chk("timeslot", timeslot, s);
    endtask

    task automatic t_regs();
        apb(0, BEC_IDX_BOOST_CTRL, 0);
        chk("boost_ctrl", rd, 32'h104);
        chk("range", boost_voltage_range, 2'h1);
        chk("feedback", boost_feedback_select, 1'b0);
        apb(0, BEC_IDX_BOOST_SLEEP, 0);
        chk("boost_sleep", rd, 32'h0);
        apb(0, BEC_IDX_EXT_CTRL, 0);
        chk("ext_ctrl", rd, 32'h0);
        apb(0, 16'h4080, 0);
        chk("slverr", er, 1'b1);
        apb(1, BEC_IDX_BOOST_CTRL, 32'h101);
        apb(0, BEC_IDX_BOOST_CTRL, 0);
        chk("locked", rd, 32'h105);
        chk("feedback", boost_feedback_select, 1'b1);
        apb(1, BEC_IDX_KEY, 32'h9716);
        apb(1, BEC_IDX_BOOST_CTRL, 32'h108);
        @(negedge pclk);
        chk("range", boost_voltage_range, 2'h2);
        apb(1, BEC_IDX_KEY, 0);
        apb(1, BEC_IDX_BOOST_CTRL, 32'h104);
        @(negedge pclk);
        chk("range", boost_voltage_range, 2'h2);
        $display("t_regs done");
    endtask

    task automatic t_up();
        apb(1, BEC_IDX_BOOST_CTRL, 32'h106);
        apb(1, BEC_IDX_EXT_CTRL, 32'h6041);
        apb(1, BEC_IDX_IRQ_MASK, 32'h7);
        power_up_req <= 1'b1;
        wt(1);
        @(posedge pclk);
        power_up_req <= 1'b0;
        chk("sleep_state", sleep_state, 1'b0);
        wt(3);
        chk("ext", external_enable_output_one, 1'b0);
        wt(5);
        chk("ext", external_enable_output_one, 1'b1);
        wt(0);
        chk("irq", irq, 1'b1);
        chk("boost", boost_enable, 1'b1);
        apb(1, BEC_IDX_IRQ_STATUS, 32'h7);
        repeat (2) @(negedge pclk);
        chk("irq", irq, 1'b0);
        $display("t_up done");
    endtask

    task automatic t_hwc();
        logic sel;
        for (int m = 0; m < 2; m++)
            for (int s = 0; s < 4; s++)
                for (int h = 0; h < 4; h++)
                begin
                    sel = (s[0] & h[0]) | (s[1] & h[1]);
                    @(posedge pclk);
                    hw_control_in1 <= h[0];
                    hw_control_in2 <= h[1];
                    apb(1, BEC_IDX_BOOST_CTRL, {16'h0, 3'h0, s[1:0], 2'h0, m[0], 8'h06});
                    apb(1, BEC_IDX_EXT_CTRL, {16'h0, 3'h3, s[1:0], 2'h0, m[0], 8'h41});
                    repeat (2) @(negedge pclk);
                    chk("boost", boost_enable, !(m[0] & sel));
                    chk("ext", external_enable_output_one, !(m[0] & sel));
                end
        for (int c = 6; c < 8; c++)
            for (int e = 0; e < 2; e++)
            begin
                @(posedge pclk);
                hw_enable1 <= e[0];
                hw_enable2 <= !e[0];
                apb(1, BEC_IDX_EXT_CTRL, {16'h0, c[2:0], 5'h0, 8'h41});
                repeat (2) @(negedge pclk);
                chk("ext", external_enable_output_one, (c == 6) ? e[0] : !e[0]);
            end
        @(posedge pclk);
        hw_control_in1 <= 1'b0;
        hw_control_in2 <= 1'b0;
        apb(1, BEC_IDX_BOOST_CTRL, 32'h106);
        apb(1, BEC_IDX_EXT_CTRL, 32'h6041);
        $display("t_hwc done");
    endtask

    task automatic t_down();
        sleep_req <= 1'b1;
        wt(5);
        @(posedge pclk);
        sleep_req <= 1'b0;
        wt(4);
        chk("ext", external_enable_output_one, 1'b1);
        wt(2);
        chk("ext", external_enable_output_one, 1'b0);
        wt(0);
        chk("sleep_state", sleep_state, 1'b1);
        chk("boost", boost_enable, 1'b0);
        apb(0, BEC_IDX_IRQ_STATUS, 0);
        chk("sleep_done", rd[2], 1'b1);
        apb(1, BEC_IDX_IRQ_STATUS, 32'h7);
        apb(1, BEC_IDX_BOOST_SLEEP, 32'h100);
        repeat (2) @(negedge pclk);
        chk("boost", boost_enable, 1'b1);
        $display("t_down done");
    endtask

    task automatic t_uv();
        for (int a = 0; a < 4; a++)
        begin
            // Code 11 is reserved and must act as ignore; its pass also masks the irq.
            apb(1, BEC_IDX_BOOST_CTRL, {16'h0, a[1:0], 14'h0106});
            if (a == 3)
                apb(1, BEC_IDX_IRQ_MASK, 0);
            @(posedge pclk);
            boost_undervoltage <= 1'b1;
            @(posedge pclk);
            boost_undervoltage <= 1'b0;
            rs = 1'b0;
            repeat (3)
            begin
                @(negedge pclk);
                rs |= system_reset_req;
            end
            chk("reset_req", rs, a == 2);
            chk("irq", irq, a != 3);
            chk("boost", boost_enable, a != 1);
            apb(0, BEC_IDX_IRQ_STATUS, 0);
            chk("uv_status", rd[0], 1'b1);
            apb(1, BEC_IDX_IRQ_STATUS, 32'h1);
            apb(1, BEC_IDX_SEQ_CTRL, 32'h1);
            repeat (2) @(negedge pclk);
            chk("irq", irq, 1'b0);
        end
        $display("t_uv done");
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_up();
        t_hwc();
        t_down();
        t_uv();
        stop_test();
    end
endmodule
